// [tpg_payload_regs.v]
// APB register bank for the test frame generator payload, firmware version
// and spare word, plus the frame byte generator they steer.
// Assumes a zero-wait APB master on ref_clk_i and a byte sink with ready.
`include "tpg_defines.vh"

module tpg_payload_regs #(
  parameter       FW_RELEASE = 1'b0,   // Arbitrary build values
  parameter [6:0] FW_MAJOR   = 7'h01,
  parameter [7:0] FW_MINOR   = 8'h00
) (
  input  wire        ref_clk_i,
  input  wire        sys_rst_i,
  input  wire        ce_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  input  wire [7:0]  dbg_data_i,
  output wire [3:0]  debug_source_select_o,
  input  wire        tx_ready_i,
  output wire        tx_valid_o,
  output wire [7:0]  tx_data_o,
  output wire        tx_last_o
);

  localparam ST_IDLE = 1'b0;
  localparam ST_SEND = 1'b1;

  reg  [15:0] payload_q;
  reg         en_q;
  reg         start_q;
  reg  [1:0]  type_q;
  reg         state_q;
  reg  [5:0]  idx_q;
  reg  [7:0]  pay_cnt_q;
  reg  [7:0]  lfsr_q;
  reg  [7:0]  data_q;
  reg  [31:0] rdata_q;
  reg         state_d;
  reg  [5:0]  idx_d;
  reg  [7:0]  pay_cnt_d;
  reg  [7:0]  lfsr_d;
  reg  [7:0]  data_d;
  reg  [31:0] rdata_d;
  reg  [7:0]  dbg_mask;
  reg  [7:0]  pay_byte;

  wire        setup_w;
  wire        access_w;
  wire        wr_w;
  wire        mapped_w;
  wire        launch_w;
  wire        advance_w;
  wire        last_w;
  wire [15:0] fw_word_w;
  wire [15:0] ctrl_word_w;
  wire [7:0]  dst_byte_w;
  wire [7:0]  src_byte_w;
  wire [2:0]  dst_sel_w;
  wire [2:0]  src_sel_w;
  wire [3:0]  dst_nib_w;
  wire [3:0]  src_nib_w;
  wire [1:0]  red_opt_w;
  wire        full_acc_w;

  assign setup_w  = psel_i & ~penable_i;
  assign access_w = psel_i & penable_i;
  assign wr_w     = access_w & pwrite_i & ce_i;
  assign mapped_w = (paddr_i == `TPG_ADDR_GEN_CTRL) |
                    (paddr_i == `TPG_ADDR_PAYLOAD) |
                    (paddr_i == `TPG_ADDR_FW_VERSION) |
                    (paddr_i == `TPG_ADDR_SPARE);

  // Zero wait states; a frozen clock enable still completes the beat
  assign pready_o  = 1'b1;
  assign pslverr_o = access_w & ~mapped_w;
  assign prdata_o  = rdata_q;

  assign fw_word_w = {FW_RELEASE[0], FW_MAJOR, FW_MINOR};
  assign ctrl_word_w = {(state_q == ST_SEND), 5'h00, type_q, 6'h00, start_q, en_q};

  // Register writes; version and spare have no storage so writes fall away
  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      payload_q <= `TPG_PAYLOAD_RST;
      en_q      <= 1'b0;
      type_q    <= `TPG_TYPE_FIXED;
      start_q   <= 1'b0;
    end else if (ce_i) begin
      if (wr_w && paddr_i == `TPG_ADDR_PAYLOAD) begin
        payload_q <= pwdata_i[15:0];
      end
      if (wr_w && paddr_i == `TPG_ADDR_GEN_CTRL) begin
        en_q   <= pwdata_i[`TPG_CTRL_EN_BIT];
        type_q <= pwdata_i[`TPG_CTRL_TYPE_HI:`TPG_CTRL_TYPE_LO];
      end
      // A new start request wins over the clear made by a launch
      if (wr_w && paddr_i == `TPG_ADDR_GEN_CTRL && pwdata_i[`TPG_CTRL_START_BIT]) begin
        start_q <= 1'b1;
      end else if (launch_w) begin
        start_q <= 1'b0;
      end
    end
  end

  // Read data captured in setup so it is stable through the access phase
  always @* begin
    if (paddr_i == `TPG_ADDR_GEN_CTRL) begin
      rdata_d = {16'h0000, ctrl_word_w};
    end else if (paddr_i == `TPG_ADDR_PAYLOAD) begin
      rdata_d = {16'h0000, payload_q};
    end else if (paddr_i == `TPG_ADDR_FW_VERSION) begin
      rdata_d = {16'h0000, fw_word_w};
    end else if (paddr_i == `TPG_ADDR_SPARE) begin
      rdata_d = {16'h0000, `TPG_SPARE_RST};
    end else begin
      rdata_d = 32'h0000_0000;
    end
  end

  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (ce_i && setup_w && !pwrite_i) begin
      rdata_q <= rdata_d;
    end
  end

  // Debug configuration view of the payload byte
  assign debug_source_select_o = payload_q[`TPG_DBG_SEL_HI:`TPG_DBG_SEL_LO];
  assign red_opt_w  = payload_q[`TPG_RED_OPT_HI:`TPG_RED_OPT_LO];
  assign full_acc_w = payload_q[`TPG_ACC_SEL_BIT];

  // Reduced accuracy drops 1, 2, 3 or 4 low bits depending on the option
  always @* begin
    if (full_acc_w) begin
      dbg_mask = 8'hFF;
    end else begin
      case (red_opt_w)
        2'h0:    dbg_mask = 8'hFE;
        2'h1:    dbg_mask = 8'hFC;
        2'h2:    dbg_mask = 8'hF8;
        default: dbg_mask = 8'hF0;
      endcase
    end
  end

  assign launch_w  = (state_q == ST_IDLE) & en_q & start_q;
  assign advance_w = (state_q == ST_SEND) & tx_ready_i;
  assign last_w    = (idx_q == `TPG_FRAME_LEN - 6'h01);

  // Next byte index for each address former; it registers one byte ahead
  assign dst_sel_w = idx_d[2:0];
  assign src_sel_w = (idx_d >= 6'h06) ? (idx_d[2:0] - 3'h6) : 3'h0;
  assign dst_nib_w = payload_q[`TPG_DST_NIB_HI:`TPG_DST_NIB_LO];
  assign src_nib_w = payload_q[`TPG_SRC_NIB_HI:`TPG_SRC_NIB_LO];

  tpg_addr_byte u_dst_addr (
    .ref_clk_i  (ref_clk_i),
    .sys_rst_i  (sys_rst_i),
    .ce_i       (ce_i),
    .nibble_i   (dst_nib_w),
    .byte_idx_i (dst_sel_w),
    .byte_o     (dst_byte_w)
  );

  tpg_addr_byte u_src_addr (
    .ref_clk_i  (ref_clk_i),
    .sys_rst_i  (sys_rst_i),
    .ce_i       (ce_i),
    .nibble_i   (src_nib_w),
    .byte_idx_i (src_sel_w),
    .byte_o     (src_byte_w)
  );

  // Payload content by type; the payload byte is content only for fixed
  always @* begin
    case (type_q)
      `TPG_TYPE_RANDOM:  pay_byte = lfsr_q;
      `TPG_TYPE_BYTEINC: pay_byte = pay_cnt_q;
      `TPG_TYPE_FIXED:   pay_byte = payload_q[7:0];
      default:           pay_byte = dbg_data_i & dbg_mask;
    endcase
  end

  // Frame sequencing
  always @* begin
    state_d   = state_q;
    idx_d     = idx_q;
    pay_cnt_d = pay_cnt_q;
    lfsr_d    = lfsr_q;
    data_d    = data_q;
    case (state_q)
      ST_IDLE: begin
        if (launch_w) begin
          state_d   = ST_SEND;
          idx_d     = 6'h00;
          pay_cnt_d = 8'h00;
        end
      end
      default: begin
        if (advance_w) begin
          if (last_w) begin
            state_d = ST_IDLE;
          end else begin
            idx_d = idx_q + 6'h01;
          end
          if (idx_q >= `TPG_HDR_LEN) begin
            pay_cnt_d = pay_cnt_q + 8'h01;
            lfsr_d    = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
          end
        end
      end
    endcase
    // data_q samples the payload byte every cycle from index 13 on, stalls included; no output uses it
    if (idx_q == `TPG_HDR_LEN - 6'h01 || idx_q >= `TPG_HDR_LEN) begin
      data_d = pay_byte;
    end
  end

  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q   <= ST_IDLE;
      idx_q     <= 6'h00;
      pay_cnt_q <= 8'h00;
      lfsr_q    <= `TPG_LFSR_SEED;
      data_q    <= 8'h00;
    end else if (ce_i) begin
      state_q   <= state_d;
      idx_q     <= idx_d;
      pay_cnt_q <= pay_cnt_d;
      lfsr_q    <= lfsr_d;
      data_q    <= data_d;
    end
  end

  // Header bytes come straight from the address formers and the fixed EtherType
  reg  [7:0]  tx_byte;
  wire [15:0] ethertype_w;

  assign ethertype_w = `TPG_ETHERTYPE;
  always @* begin
    if (idx_q < 6'h06) begin
      tx_byte = dst_byte_w;
    end else if (idx_q < 6'h0C) begin
      tx_byte = src_byte_w;
    end else if (idx_q == 6'h0C) begin
      tx_byte = ethertype_w[15:8];
    end else if (idx_q == 6'h0D) begin
      tx_byte = ethertype_w[7:0];
    end else begin
      tx_byte = pay_byte;
    end
  end

  assign tx_valid_o = (state_q == ST_SEND);
  assign tx_data_o  = (idx_q < `TPG_HDR_LEN) ? tx_byte : pay_byte;
  assign tx_last_o  = tx_valid_o & last_w;

endmodule // tpg_payload_regs

// [tpg_defines.vh]
// Constants for the test frame payload and firmware version register bank.
// Assumes word-indexed register offsets placed on APB at four bytes per index.
`ifndef TPG_DEFINES_VH
`define TPG_DEFINES_VH

// Register indices and their APB byte addresses (index times four)
`define TPG_IDX_GEN_CTRL     8'h1C
`define TPG_IDX_PAYLOAD      8'h1D
`define TPG_IDX_FW_VERSION   8'h1E
`define TPG_IDX_SPARE        8'h1F
`define TPG_ADDR_GEN_CTRL    8'h70
`define TPG_ADDR_PAYLOAD     8'h74
`define TPG_ADDR_FW_VERSION  8'h78
`define TPG_ADDR_SPARE       8'h7C

// Reset values
`define TPG_PAYLOAD_RST      16'h00AA
`define TPG_SPARE_RST        16'h0000

// Payload register fields
`define TPG_DST_NIB_HI       15
`define TPG_DST_NIB_LO       12
`define TPG_SRC_NIB_HI       11
`define TPG_SRC_NIB_LO       8
`define TPG_DBG_SEL_HI       3
`define TPG_DBG_SEL_LO       0
`define TPG_RED_OPT_HI       6
`define TPG_RED_OPT_LO       5
`define TPG_ACC_SEL_BIT      7

// Generator control fields
`define TPG_CTRL_EN_BIT      0
`define TPG_CTRL_START_BIT   1
`define TPG_CTRL_TYPE_HI     9
`define TPG_CTRL_TYPE_LO     8
`define TPG_CTRL_BUSY_BIT    15

// Content type codes
`define TPG_TYPE_RANDOM      2'h0
`define TPG_TYPE_BYTEINC     2'h1
`define TPG_TYPE_FIXED       2'h2
`define TPG_TYPE_DEBUG       2'h3

// Frame layout, FCS excluded
`define TPG_FRAME_LEN        6'h3C
`define TPG_HDR_LEN          6'h0E
`define TPG_ETHERTYPE        16'h88B5
`define TPG_LFSR_SEED        8'hA5

`endif

// [tpg_addr_byte.v]
// Forms one byte of a generated MAC address from its configured low nibble.
// Assumes the caller steps byte_idx_i from 0 (first sent) to 5.
module tpg_addr_byte #(
  parameter [23:0] PREFIX = 24'h02_00_00  // Arbitrary neutral prefix
) (
  input  wire       ref_clk_i,
  input  wire       sys_rst_i,
  input  wire       ce_i,
  input  wire [3:0] nibble_i,
  input  wire [2:0] byte_idx_i,
  output wire [7:0] byte_o
);

  wire [47:0] addr_w;
  reg  [7:0]  byte_q;

  // Prefix, then all-ones, then the configured nibble in the lowest place
  assign addr_w = {PREFIX, 8'hFF, 8'hFF, 4'hF, nibble_i};

  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      byte_q <= 8'h00;
    end else if (ce_i) begin
      case (byte_idx_i)
        3'h0:    byte_q <= addr_w[47:40];
        3'h1:    byte_q <= addr_w[39:32];
        3'h2:    byte_q <= addr_w[31:24];
        3'h3:    byte_q <= addr_w[23:16];
        3'h4:    byte_q <= addr_w[15:8];
        default: byte_q <= addr_w[7:0];
      endcase
    end
  end

  assign byte_o = byte_q;

endmodule // tpg_addr_byte

// [tfp_regs_properties.sv]
// Port checker for the payload, version and spare register bank.
// Assumes the generator control word at 0x70 with its type in bits 9:8.
module tfp_regs_properties #(
  parameter       FW_RELEASE = 1'b0,
  parameter [6:0] FW_MAJOR   = 7'h01,
  parameter [7:0] FW_MINOR   = 8'h00
) (
  input wire logic        ref_clk_i,
  input wire logic        sys_rst_i,
  input wire logic        ce_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pslverr_o,
  input wire logic [7:0]  dbg_data_i,
  input wire logic [3:0]  debug_source_select_o,
  input wire logic        tx_ready_i,
  input wire logic        tx_valid_o,
  input wire logic [7:0]  tx_data_o,
  input wire logic        tx_last_o
);
  logic [15:0] pay_q;
  logic [1:0]  typ_q;
  logic [5:0]  cnt_q;
  wire         wr  = psel_i && penable_i && pwrite_i && ce_i;
  wire         rd  = psel_i && !penable_i && !pwrite_i && ce_i;
  wire         hit = paddr_i[7:4] == 4'h7 && paddr_i[1:0] == 2'h0;
  wire         pl  = tx_valid_o && cnt_q > 6'h0D;
  wire [7:0]   msk = pay_q[7] ? 8'hFF : 8'hFF << (pay_q[6:5] + 3'h1);

  // Shadow of the payload word, content type and byte position
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pay_q <= 16'h00AA;
      typ_q <= 2'h2;
      cnt_q <= 6'h00;
    end else begin
      if (wr && paddr_i == 8'h74) pay_q <= pwdata_i[15:0];
      if (wr && paddr_i == 8'h70) typ_q <= pwdata_i[9:8];
      if (tx_valid_o && tx_ready_i && ce_i) cnt_q <= tx_last_o ? 6'h00 : cnt_q + 6'h01;
    end
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_unmapped_err: assert property (psel_i && penable_i && !hit |-> pslverr_o)
    else $error("no error on unmapped address");
  a_spare_zero: assert property (rd && paddr_i == 8'h7C |=> prdata_o == 32'h0)
    else $error("spare word not zero");
  a_fw_value: assert property (rd && paddr_i == 8'h78 |=>
    prdata_o == {16'h0000, FW_RELEASE != 0, FW_MAJOR, FW_MINOR})
    else $error("version word wrong");
  a_dbg_select: assert property (debug_source_select_o == pay_q[3:0])
    else $error("debug select wrong");
  a_fixed_payload: assert property (pl && typ_q == 2'h2 |-> tx_data_o == pay_q[7:0])
    else $error("fixed payload wrong");
  a_dst_nibble: assert property (tx_valid_o && cnt_q == 6'h05 |->
    tx_data_o == {4'hF, pay_q[15:12]})
    else $error("destination nibble wrong");
  a_src_nibble: assert property (tx_valid_o && cnt_q == 6'h0B |->
    tx_data_o == {4'hF, pay_q[11:8]})
    else $error("source nibble wrong");
  a_debug_mask: assert property (pl && typ_q == 2'h3 |->
    tx_data_o == (dbg_data_i & msk))
    else $error("debug payload wrong");
endmodule // tfp_regs_properties

bind tpg_payload_regs tfp_regs_properties #(.FW_RELEASE(FW_RELEASE), .FW_MAJOR(FW_MAJOR),
  .FW_MINOR(FW_MINOR)) u_props (.ref_clk_i, .sys_rst_i, .ce_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pslverr_o, .dbg_data_i,
  .debug_source_select_o, .tx_ready_i, .tx_valid_o, .tx_data_o, .tx_last_o);

// [test_frame_payload_and_fw_version_regs_tb.sv]
// Self-checking bench for the payload, version and spare register bank.
// Assumes a zero-wait APB slave and the generator control word at 0x70.
module test_frame_payload_and_fw_version_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_i, sys_rst_i, ce_i, psel_i, penable_i, pwrite_i, tx_ready_i;
  logic        pready_o, pslverr_o, tx_valid_o, tx_last_o, err_v;
  logic [7:0]  paddr_i, dbg_data_i, tx_data_o;
  logic [31:0] pwdata_i, prdata_o, rd_v, w;
  logic [3:0]  debug_source_select_o;
  logic [15:0] pay;
  int          err_total, num_checks, seed;
  // Build values are arbitrary
  localparam logic [15:0] FW = 16'hAA5C;

  tpg_payload_regs #(.FW_RELEASE(1'b1), .FW_MAJOR(7'h2A), .FW_MINOR(8'h5C)) DUT (
    .ref_clk_i, .sys_rst_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .dbg_data_i, .debug_source_select_o,
    .tx_ready_i, .tx_valid_o, .tx_data_o, .tx_last_o);

  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  // Random sink stalls and debug samples every cycle
  always @(posedge ref_clk_i) begin
    tx_ready_i <= $random(seed);
    dbg_data_i <= $random(seed);
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Idle edge first, so a release is never overwritten in the same step
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 100);
    if (n >= 100) begin
      err_total++;
      wrap_up();
    end
    rd_v = prdata_o;
    err_v = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic frame(logic [1:0] ty);
    logic [7:0] e;
    int n;
    apb(1'b1, 8'h70, {22'h0, ty, 8'h03});
    for (int i = 0; i < 60; i++) begin
      n = 0;
      do begin
        @(negedge ref_clk_i);
        n++;
      end while (!(tx_valid_o === 1'b1 && tx_ready_i === 1'b1) && n < 200);
      if (n >= 200) begin
        err_total++;
        wrap_up();
      end
      case (i % 6)
        0: e = 8'h02;
        1, 2: e = 8'h00;
        3, 4: e = 8'hFF;
        default: e = {4'hF, (i < 6) ? pay[15:12] : pay[11:8]};
      endcase
      if (i == 12) e = 8'h88;
      if (i == 13) e = 8'hB5;
      if (i > 13) e = ty == 2'h1 ? 8'(i - 14) : ty == 2'h2 ? pay[7:0] :
        dbg_data_i & (pay[7] ? 8'hFF : 8'hFF << (pay[6:5] + 1));
      if (i < 14 || ty != 2'h0) chk("tx byte", {i == 59, e}, {tx_last_o, tx_data_o});
    end
  endtask

  initial begin
    seed = 32'hBBC2;
    {sys_rst_i, ce_i} = 2'b11;
    {psel_i, penable_i, pwrite_i, tx_ready_i} = 4'h0;
    {paddr_i, dbg_data_i, pwdata_i} = 48'h0;
    repeat (5) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    apb(1'b0, 8'h74, 32'h0);
    chk("payload reset", 32'h00AA, rd_v);
    apb(1'b1, 8'h78, $random(seed));
    apb(1'b1, 8'h7C, 32'h0);
    apb(1'b0, 8'h78, 32'h0);
    chk("version", {16'h0, FW}, rd_v);
    apb(1'b0, 8'h7C, 32'h0);
    chk("spare", 32'h0, rd_v);
    chk("spare error", 1'b0, err_v);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped error", 1'b1, err_v);
    $display("register test done");
    // Debug frames walk all reduced options and full accuracy
    for (int k = 0; k < 20; k++) begin
      pay = $random(seed);
      pay[7:5] = k[4:2];
      w = $random(seed);
      w[15:0] = pay;
      apb(1'b1, 8'h74, w);
      apb(1'b0, 8'h74, 32'h0);
      chk("payload", {16'h0, pay}, rd_v);
      chk("debug select", pay[3:0], debug_source_select_o);
      frame(k[1:0]);
    end
    $display("frame test done");
    wrap_up();
  end
endmodule // test_frame_payload_and_fw_version_regs_tb
